/* File: common/pdsc_pkg.sv */
package pdsc_pkg;

  // ---------------------------------------------------------------
  // Register offsets, page 0
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_PAGE_SELECT = 8'h00;
  localparam logic [7:0] OFS_PLL_FRACTION_HIGH = 8'h05;
  localparam logic [7:0] OFS_PLL_FRACTION_LOW = 8'h06;
  localparam logic [7:0] OFS_DATAPATH_SETUP = 8'h07;
  localparam logic [7:0] OFS_SERIAL_PORT_CONTROL_A = 8'h08;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_PLL_FRACTION_HIGH = 8'h00;
  localparam logic [5:0] RST_PLL_FRACTION_LOW = 6'h00;
  localparam logic [7:0] RST_DATAPATH_SETUP = 8'h00;
  localparam logic [7:0] RST_SERIAL_PORT_CONTROL_A = 8'h00;
  localparam logic RST_PAGE = 1'b0;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int FRAC_LOW_LSB = 2;
  localparam int DP_REF_RATE = 7;
  localparam int DP_ADC_DUAL = 6;
  localparam int DP_DAC_DUAL = 5;
  localparam int DP_LEFT_LSB = 3;
  localparam int DP_RIGHT_LSB = 1;
  localparam int SP_BIT_MASTER = 7;
  localparam int SP_WORD_MASTER = 6;
  localparam int SP_TRISTATE = 5;
  localparam int SP_KEEP_CLOCKS = 4;
  localparam int SP_EFFECT_3D = 2;
  localparam int SP_DMIC_LSB = 0;

  // ---------------------------------------------------------------
  // Field codes
  // ---------------------------------------------------------------
  localparam logic [1:0] ROUTE_MUTE = 2'h0;
  localparam logic [1:0] DMIC_OFF = 2'h0;
  localparam logic [1:0] DMIC_OSR128 = 2'h1;
  localparam logic [1:0] DMIC_OSR64 = 2'h2;
  localparam logic [7:0] OSR_128 = 8'h80;
  localparam logic [7:0] OSR_64 = 8'h40;
  localparam logic [7:0] OSR_32 = 8'h20;

  // ---------------------------------------------------------------
  // Serial clock generation
  // ---------------------------------------------------------------
  localparam int BIT_CLK_HALF_CYCLES = 4;
  localparam int BITS_PER_WORD_HALF = 32;

endpackage : pdsc_pkg

/* File: core/pdsc_i2c_slave.sv */
`timescale 1ns/10ps
module pdsc_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h2A // Arbitrary value
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_pin,
  input wire logic sda_pin,
  output logic sda_oe,
  output logic [7:0] reg_ptr,
  output logic wr_en,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data
);

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_RX = 5'b00010,
    S_ACK = 5'b00100,
    S_TX = 5'b01000,
    S_RACK = 5'b10000
  } pdsc_i2c_e;

  // ---------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ---------------------------------------------------------------
  logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {scl_m, scl_s, scl_p} <= 3'h7;
      {sda_m, sda_s, sda_p} <= 3'h7;
    end else begin
      {scl_m, scl_s, scl_p} <= {scl_pin, scl_m, scl_s};
      {sda_m, sda_s, sda_p} <= {sda_pin, sda_m, sda_s};
    end
  end

  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_s & ~scl_p;
  assign scl_fall = ~scl_s & scl_p;
  assign start_c = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_c = scl_s & scl_p & ~sda_p & sda_s;

  // ---------------------------------------------------------------
  // Byte engine
  // ---------------------------------------------------------------
  pdsc_i2c_e state;
  logic [1:0] phase; // 0 address, 1 pointer, 2 data
  logic [3:0] cnt;
  logic [7:0] sh;
  logic is_read, master_ack;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= S_IDLE;
      phase <= 2'h0;
      cnt <= 4'h0;
      sh <= 8'h00;
      is_read <= 1'b0;
      master_ack <= 1'b0;
      sda_oe <= 1'b0;
      reg_ptr <= 8'h00;
      wr_en <= 1'b0;
      wr_data <= 8'h00;
    end else begin
      wr_en <= 1'b0;
      if (start_c) begin
        state <= S_RX;
        phase <= 2'h0;
        cnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop_c) begin
        state <= S_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          S_IDLE: begin
            sda_oe <= 1'b0;
          end
          S_RX: begin
            if (scl_rise && cnt < 4'h8) begin
              sh <= {sh[6:0], sda_s};
              cnt <= cnt + 4'h1;
            end else if (scl_fall && cnt == 4'h8) begin
              cnt <= 4'h0;
              if (phase == 2'h0) begin
                if (sh[7:1] == DEV_ADDR) begin
                  is_read <= sh[0];
                  sda_oe <= 1'b1;
                  state <= S_ACK;
                end else begin
                  state <= S_IDLE;
                end
              end else begin
                if (phase == 2'h1) begin
                  reg_ptr <= sh;
                end else begin
                  wr_data <= sh;
                  wr_en <= 1'b1;
                end
                sda_oe <= 1'b1;
                state <= S_ACK;
              end
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              if (phase == 2'h0 && is_read) begin
                sda_oe <= ~rd_data[7];
                sh <= {rd_data[6:0], 1'b0};
                reg_ptr <= reg_ptr + 8'h01;
                cnt <= 4'h1;
                state <= S_TX;
              end else begin
                if (phase == 2'h2) begin
                  reg_ptr <= reg_ptr + 8'h01;
                end
                phase <= (phase == 2'h0) ? 2'h1 : 2'h2;
                sda_oe <= 1'b0;
                state <= S_RX;
              end
            end
          end
          S_TX: begin
            if (scl_fall) begin
              if (cnt == 4'h8) begin
                sda_oe <= 1'b0;
                state <= S_RACK;
              end else begin
                sda_oe <= ~sh[7];
                sh <= {sh[6:0], 1'b0};
                cnt <= cnt + 4'h1;
              end
            end
          end
          S_RACK: begin
            if (scl_rise) begin
              master_ack <= ~sda_s;
            end else if (scl_fall) begin
              if (master_ack) begin
                sda_oe <= ~rd_data[7];
                sh <= {rd_data[6:0], 1'b0};
                reg_ptr <= reg_ptr + 8'h01;
                cnt <= 4'h1;
                state <= S_TX;
              end else begin
                state <= S_IDLE;
              end
            end
          end
          default: begin
            state <= S_IDLE;
          end
        endcase
      end
    end
  end

endmodule : pdsc_i2c_slave

/* File: core/pdsc_config_bank.sv */
`timescale 1ns/10ps
// How it works
// [RULE1] Fraction high register holds the upper eight of fourteen fraction bits.
// [RULE2] Fraction low register bits 7..2 hold the lower six fraction bits.
// [RULE3] Host never programs a fraction above 9999.
// [RULE4] Host writes high register then low register on every fraction change.
// [RULE5] The combined fraction reaches the PLL when the low register is written.
// [RULE6] Low register bits 1..0 are read-only zero; host writes zeros.
// [RULE7] Data-path bit 7 picks the AGC reference rate: 48 kHz or 44.1 kHz.
// [RULE8] Data-path bit 6 enables ADC dual-rate mode.
// [RULE9] Data-path bit 5 enables DAC dual-rate mode.
// [RULE10] Host keeps ADC dual-rate equal to DAC dual-rate.
// [RULE11] Bits 4..3 route the left DAC: mute, left, right, mono mix.
// [RULE12] Bits 2..1 route the right DAC: mute, right, left, mono mix.
// [RULE13] Host writes zero to data-path bit 0.
// [RULE14] Serial bit 7 makes the bit clock pin an output in master mode.
// [RULE15] Serial bit 6 makes the word clock pin an output in master mode.
// [RULE16] Serial bit 5 floats data output whenever no valid data is sent.
// [RULE17] Serial bit 4 keeps master clocks running while the codec is down.
// [RULE18] Host leaves serial bit 3 unwritten.
// [RULE19] Serial bit 2 enables the 3-D effect.
// [RULE20] Serial bits 1..0 set microphone mode: off, or oversampling 128, 64, 32.
// [RULE21] Every register is eight bits wide, reached over the I2C bus.
// [RULE22] These registers sit on page 0, chosen by page-select bit zero.
module pdsc_config_bank #(
  parameter logic [6:0] DEV_ADDR = 7'h2A, // Arbitrary value
  parameter int BIT_CLK_HALF = pdsc_pkg::BIT_CLK_HALF_CYCLES,
  parameter int WORD_HALF_BITS = pdsc_pkg::BITS_PER_WORD_HALF
) (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  output logic [13:0] PLL_FRACTION,
  output logic AGC_REF_44K1,
  output logic ADC_DUAL_RATE,
  output logic DAC_DUAL_RATE,
  output logic [1:0] LEFT_DAC_ROUTE,
  output logic [1:0] RIGHT_DAC_ROUTE,
  output logic EFFECT_3D_EN,
  output logic DMIC_EN,
  output logic [7:0] DMIC_OVERSAMPLE,
  input wire logic CODEC_POWERED,
  input wire logic USE_ALT_BIT_CLK,
  input wire logic USE_ALT_WORD_CLK,
  input wire logic BIT_CLK_IN,
  output logic BIT_CLK_OUT,
  output logic BIT_CLK_OE,
  input wire logic ALT_BIT_CLK_PIN_IN,
  output logic ALT_BIT_CLK_PIN_OUT,
  output logic ALT_BIT_CLK_PIN_OE,
  input wire logic WORD_CLK_IN,
  output logic WORD_CLK_OUT,
  output logic WORD_CLK_OE,
  input wire logic ALT_WORD_CLK_PIN_IN,
  output logic ALT_WORD_CLK_PIN_OUT,
  output logic ALT_WORD_CLK_PIN_OE,
  output logic BIT_TICK,
  output logic FRAME_TICK,
  input wire logic TX_DATA,
  input wire logic TX_VALID,
  output logic SDOUT_OUT,
  output logic SDOUT_OE
);

  if (BIT_CLK_HALF < 1 || BIT_CLK_HALF > 255 || WORD_HALF_BITS < 1 || WORD_HALF_BITS > 255) begin : g_bad_divider
    $error("pdsc_config_bank: clock divider parameters out of range");
  end

  function automatic logic [7:0] osr_of(input logic [1:0] code);
    case (code)
      pdsc_pkg::DMIC_OFF: osr_of = 8'h00;
      pdsc_pkg::DMIC_OSR128: osr_of = pdsc_pkg::OSR_128;
      pdsc_pkg::DMIC_OSR64: osr_of = pdsc_pkg::OSR_64;
      default: osr_of = pdsc_pkg::OSR_32;
    endcase
  endfunction : osr_of

  // ---------------------------------------------------------------
  // Control bus
  // ---------------------------------------------------------------
  logic [7:0] reg_ptr, wr_data, rd_data;
  logic wr_en, sda_oe;

  pdsc_i2c_slave #(.DEV_ADDR(DEV_ADDR)) u_i2c (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .scl_pin(SCL_IN),
    .sda_pin(SDA_IN),
    .sda_oe(sda_oe),
    .reg_ptr(reg_ptr),
    .wr_en(wr_en),
    .wr_data(wr_data),
    .rd_data(rd_data)
  );

  assign SDA_OUT = 1'b0;
  assign SDA_OE = sda_oe;

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic page;
  logic [7:0] frac_high;
  logic [5:0] frac_low;
  logic [7:0] datapath;
  logic [7:0] serctl;
  logic on_page0;
  assign on_page0 = ~page;

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      page <= pdsc_pkg::RST_PAGE;
    end else if (wr_en && reg_ptr == pdsc_pkg::OFS_PAGE_SELECT) begin
      page <= wr_data[0]; // [RULE22]
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      frac_high <= pdsc_pkg::RST_PLL_FRACTION_HIGH;
      frac_low <= pdsc_pkg::RST_PLL_FRACTION_LOW;
      datapath <= pdsc_pkg::RST_DATAPATH_SETUP;
      serctl <= pdsc_pkg::RST_SERIAL_PORT_CONTROL_A;
    end else if (wr_en && on_page0) begin
      case (reg_ptr) // [RULE21]
        pdsc_pkg::OFS_PLL_FRACTION_HIGH: frac_high <= wr_data; // [RULE1]
        pdsc_pkg::OFS_PLL_FRACTION_LOW: frac_low <= wr_data[7:pdsc_pkg::FRAC_LOW_LSB]; // [RULE2]
        pdsc_pkg::OFS_DATAPATH_SETUP: datapath <= {wr_data[7:1], 1'b0};
        pdsc_pkg::OFS_SERIAL_PORT_CONTROL_A: serctl <= wr_data;
        default: begin
        end
      endcase
    end
  end

  // Fraction moves to the PLL as one word on the low-half write
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      PLL_FRACTION <= {pdsc_pkg::RST_PLL_FRACTION_HIGH, pdsc_pkg::RST_PLL_FRACTION_LOW};
    end else if (wr_en && on_page0 && reg_ptr == pdsc_pkg::OFS_PLL_FRACTION_LOW) begin
      PLL_FRACTION <= {frac_high, wr_data[7:pdsc_pkg::FRAC_LOW_LSB]}; // [RULE5] [RULE4]
    end
  end

  always_comb begin
    rd_data = 8'h00;
    if (reg_ptr == pdsc_pkg::OFS_PAGE_SELECT) begin
      rd_data = {7'h00, page};
    end else if (on_page0) begin
      case (reg_ptr)
        pdsc_pkg::OFS_PLL_FRACTION_HIGH: rd_data = frac_high;
        pdsc_pkg::OFS_PLL_FRACTION_LOW: rd_data = {frac_low, 2'h0}; // [RULE6]
        pdsc_pkg::OFS_DATAPATH_SETUP: rd_data = datapath;
        pdsc_pkg::OFS_SERIAL_PORT_CONTROL_A: rd_data = serctl;
        default: rd_data = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Data-path and effect controls
  // ---------------------------------------------------------------
  assign AGC_REF_44K1 = datapath[pdsc_pkg::DP_REF_RATE]; // [RULE7]
  assign ADC_DUAL_RATE = datapath[pdsc_pkg::DP_ADC_DUAL]; // [RULE8]
  assign DAC_DUAL_RATE = datapath[pdsc_pkg::DP_DAC_DUAL]; // [RULE9]
  assign LEFT_DAC_ROUTE = datapath[pdsc_pkg::DP_LEFT_LSB +: 2]; // [RULE11]
  assign RIGHT_DAC_ROUTE = datapath[pdsc_pkg::DP_RIGHT_LSB +: 2]; // [RULE12]
  assign EFFECT_3D_EN = serctl[pdsc_pkg::SP_EFFECT_3D]; // [RULE19]

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      DMIC_EN <= 1'b0;
      DMIC_OVERSAMPLE <= 8'h00;
    end else begin
      DMIC_EN <= serctl[pdsc_pkg::SP_DMIC_LSB +: 2] != pdsc_pkg::DMIC_OFF; // [RULE20]
      DMIC_OVERSAMPLE <= osr_of(serctl[pdsc_pkg::SP_DMIC_LSB +: 2]); // [RULE20]
    end
  end

  // ---------------------------------------------------------------
  // Serial clock pins
  // ---------------------------------------------------------------
  logic bit_master, word_master, run_clocks;
  assign bit_master = serctl[pdsc_pkg::SP_BIT_MASTER];
  assign word_master = serctl[pdsc_pkg::SP_WORD_MASTER];
  assign run_clocks = CODEC_POWERED | serctl[pdsc_pkg::SP_KEEP_CLOCKS]; // [RULE17]

  logic [7:0] div_cnt, bit_cnt;
  logic gen_bclk, gen_wclk, gen_rise;
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      div_cnt <= 8'h00;
      bit_cnt <= 8'h00;
      gen_bclk <= 1'b0;
      gen_wclk <= 1'b0;
      gen_rise <= 1'b0;
    end else begin
      gen_rise <= 1'b0;
      if (run_clocks && (bit_master || word_master)) begin // [RULE17]
        if (div_cnt == 8'(BIT_CLK_HALF - 1)) begin
          div_cnt <= 8'h00;
          gen_bclk <= ~gen_bclk;
          if (!gen_bclk) begin
            gen_rise <= 1'b1;
            if (bit_cnt == 8'(WORD_HALF_BITS - 1)) begin
              bit_cnt <= 8'h00;
              gen_wclk <= ~gen_wclk;
            end else begin
              bit_cnt <= bit_cnt + 8'h01;
            end
          end
        end else begin
          div_cnt <= div_cnt + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      BIT_CLK_OUT <= 1'b0;
      BIT_CLK_OE <= 1'b0;
      ALT_BIT_CLK_PIN_OUT <= 1'b0;
      ALT_BIT_CLK_PIN_OE <= 1'b0;
      WORD_CLK_OUT <= 1'b0;
      WORD_CLK_OE <= 1'b0;
      ALT_WORD_CLK_PIN_OUT <= 1'b0;
      ALT_WORD_CLK_PIN_OE <= 1'b0;
    end else begin
      BIT_CLK_OUT <= gen_bclk;
      ALT_BIT_CLK_PIN_OUT <= gen_bclk;
      WORD_CLK_OUT <= gen_wclk;
      ALT_WORD_CLK_PIN_OUT <= gen_wclk;
      BIT_CLK_OE <= bit_master & ~USE_ALT_BIT_CLK; // [RULE14]
      ALT_BIT_CLK_PIN_OE <= bit_master & USE_ALT_BIT_CLK; // [RULE14]
      WORD_CLK_OE <= word_master & ~USE_ALT_WORD_CLK; // [RULE15]
      ALT_WORD_CLK_PIN_OE <= word_master & USE_ALT_WORD_CLK; // [RULE15]
    end
  end

  // Slave clocks come from pins; two flops before any edge logic
  logic bclk_m, bclk_s, bclk_p, wclk_m, wclk_s, wclk_p, gen_wclk_p;
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      {bclk_m, bclk_s, bclk_p} <= 3'h0;
      {wclk_m, wclk_s, wclk_p} <= 3'h0;
      gen_wclk_p <= 1'b0;
    end else begin
      bclk_m <= USE_ALT_BIT_CLK ? ALT_BIT_CLK_PIN_IN : BIT_CLK_IN;
      wclk_m <= USE_ALT_WORD_CLK ? ALT_WORD_CLK_PIN_IN : WORD_CLK_IN;
      {bclk_s, bclk_p} <= {bclk_m, bclk_s};
      {wclk_s, wclk_p} <= {wclk_m, wclk_s};
      gen_wclk_p <= gen_wclk;
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      BIT_TICK <= 1'b0;
      FRAME_TICK <= 1'b0;
    end else begin
      BIT_TICK <= bit_master ? gen_rise : (bclk_s & ~bclk_p);
      FRAME_TICK <= word_master ? (gen_wclk & ~gen_wclk_p) : (wclk_s & ~wclk_p);
    end
  end

  // ---------------------------------------------------------------
  // Serial data output
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      SDOUT_OUT <= 1'b0;
      SDOUT_OE <= 1'b0;
    end else begin
      SDOUT_OUT <= TX_DATA;
      SDOUT_OE <= ~serctl[pdsc_pkg::SP_TRISTATE] | TX_VALID; // [RULE16]
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);

  property p_frac_commit;
    wr_en && on_page0 && reg_ptr == pdsc_pkg::OFS_PLL_FRACTION_LOW
      |=> PLL_FRACTION == {$past(frac_high), $past(wr_data[7:2])};
  endproperty
  a_frac_commit: assert property (p_frac_commit) else $error("fraction not committed"); // [RULE5]

  property p_frac_hold;
    !(wr_en && reg_ptr == pdsc_pkg::OFS_PLL_FRACTION_LOW) |=> $stable(PLL_FRACTION);
  endproperty
  a_frac_hold: assert property (p_frac_hold) else $error("fraction changed early"); // [RULE5]

  property p_low_reserved;
    on_page0 && reg_ptr == pdsc_pkg::OFS_PLL_FRACTION_LOW |-> rd_data[1:0] == 2'h0 && rd_data[7:2] == frac_low;
  endproperty
  a_low_reserved: assert property (p_low_reserved) else $error("low fraction read wrong"); // [RULE6]

  property p_datapath_write;
    wr_en && on_page0 && reg_ptr == pdsc_pkg::OFS_DATAPATH_SETUP
      |=> AGC_REF_44K1 == $past(wr_data[7]) && ADC_DUAL_RATE == $past(wr_data[6])
        && DAC_DUAL_RATE == $past(wr_data[5]);
  endproperty
  a_datapath_write: assert property (p_datapath_write) else $error("data-path bits not taken"); // [RULE7]

  property p_routes;
    wr_en && on_page0 && reg_ptr == pdsc_pkg::OFS_DATAPATH_SETUP
      |=> LEFT_DAC_ROUTE == $past(wr_data[4:3]) && RIGHT_DAC_ROUTE == $past(wr_data[2:1]);
  endproperty
  a_routes: assert property (p_routes) else $error("DAC routing not taken"); // [RULE11]

  property p_bit_dir;
    ##1 BIT_CLK_OE == $past(bit_master && !USE_ALT_BIT_CLK)
      && ALT_BIT_CLK_PIN_OE == $past(bit_master && USE_ALT_BIT_CLK);
  endproperty
  a_bit_dir: assert property (p_bit_dir) else $error("bit clock direction wrong"); // [RULE14]

  property p_word_dir;
    !word_master |=> !WORD_CLK_OE && !ALT_WORD_CLK_PIN_OE;
  endproperty
  a_word_dir: assert property (p_word_dir) else $error("word clock driven in slave mode"); // [RULE15]

  property p_tristate;
    serctl[pdsc_pkg::SP_TRISTATE] && !TX_VALID |=> !SDOUT_OE;
  endproperty
  a_tristate: assert property (p_tristate) else $error("data output not floated"); // [RULE16]

  property p_clock_stop;
    (!CODEC_POWERED && !serctl[pdsc_pkg::SP_KEEP_CLOCKS])[*3] |-> $stable(BIT_CLK_OUT) && $stable(WORD_CLK_OUT);
  endproperty
  a_clock_stop: assert property (p_clock_stop) else $error("clocks ran while stopped"); // [RULE17]

  property p_dmic;
    ##1 DMIC_OVERSAMPLE == ($past(serctl[1:0]) == 2'h0 ? 8'h00 : 8'(9'h100 >> $past(serctl[1:0])))
      && DMIC_EN == ($past(serctl[1:0]) != 2'h0);
  endproperty
  a_dmic: assert property (p_dmic) else $error("microphone setting wrong"); // [RULE20]

  property p_page1_blocks;
    wr_en && page && reg_ptr == pdsc_pkg::OFS_SERIAL_PORT_CONTROL_A |=> $stable(serctl);
  endproperty
  a_page1_blocks: assert property (p_page1_blocks) else $error("page 1 write reached page 0"); // [RULE22]

endmodule : pdsc_config_bank

/* File: verification/pdsc_i2c_host.sv */
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Control bus master, SCL period 80 ns, SDA with pull-up
// ---------------------------------------------------------------
module pdsc_i2c_host #(
  parameter logic [6:0] DEV_ADDR = 7'h2A // Arbitrary value
) (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  int nacks = 0;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic q(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : q
  // Nine bits MSB first; data moves mid-low and is taken at the SCL rise
  task automatic xb(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      q(2);
      sda_low = ~d[i];
      q(3);
      scl = 1'b1;
      r[i] = sda;
      q(5);
      scl = 1'b0;
    end
  endtask : xb
  // SDA moves while SCL high: start when a=0,b=1, stop when a=1,b=0
  task automatic cond(input logic a, input logic b);
    q(2);
    sda_low = a;
    q(3);
    scl = 1'b1;
    q(5);
    sda_low = b;
    q(5);
  endtask : cond
  task automatic sb(input logic [7:0] b);
    logic [8:0] r;
    xb({b, 1'b1}, r);
    nacks += int'(r[0]);
  endtask : sb
  task automatic wr(input logic [7:0] o, input logic [7:0] v);
    cond(1'b0, 1'b1);
    scl = 1'b0;
    sb({DEV_ADDR, 1'b0});
    sb(o);
    sb(v);
    cond(1'b1, 1'b0);
  endtask : wr
  task automatic rd(input logic [7:0] o, output logic [7:0] v);
    logic [8:0] r;
    cond(1'b0, 1'b1);
    scl = 1'b0;
    sb({DEV_ADDR, 1'b0});
    sb(o);
    cond(1'b0, 1'b1);
    scl = 1'b0;
    sb({DEV_ADDR, 1'b1});
    xb(9'h1FF, r);
    v = r[8:1];
    cond(1'b1, 1'b0);
  endtask : rd
endmodule : pdsc_i2c_host

/* File: verification/pdsc_config_bank_test.sv */
`timescale 1ns/10ps
module pdsc_config_bank_test;
  logic clk, rst, pwr, alt_b, alt_w, tx_data, tx_valid, scl, sda_low, sda_oe, sda;
  logic agc, adc, dac, e3d, dm_en, bco, bco_e, abc_e, wco, wco_e, awc_e, sd_o, sd_e, run, t;
  logic btk, ftk, abco, awco, sdo, lclk;
  logic [1:0] lr, rr;
  logic [7:0] dm_os, v, bt, wt;
  logic [13:0] pll, f, d;
  logic [7:0] m [0:255];
  logic [7:0] osr [0:3] = '{8'h00, 8'h80, 8'h40, 8'h20};
  int errors = 0;
  int total_checks = 0;
  assign sda = ~(sda_low | sda_oe);
  pdsc_config_bank #(.BIT_CLK_HALF(4), .WORD_HALF_BITS(2)) u_pdsc_config_bank (
    .CORE_CLK(clk), .SYS_RST(rst), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sdo), .SDA_OE(sda_oe),
    .PLL_FRACTION(pll), .AGC_REF_44K1(agc), .ADC_DUAL_RATE(adc), .DAC_DUAL_RATE(dac),
    .LEFT_DAC_ROUTE(lr), .RIGHT_DAC_ROUTE(rr), .EFFECT_3D_EN(e3d), .DMIC_EN(dm_en),
    .DMIC_OVERSAMPLE(dm_os), .CODEC_POWERED(pwr), .USE_ALT_BIT_CLK(alt_b), .USE_ALT_WORD_CLK(alt_w),
    .BIT_CLK_IN(lclk), .BIT_CLK_OUT(bco), .BIT_CLK_OE(bco_e), .ALT_BIT_CLK_PIN_IN(1'b0),
    .ALT_BIT_CLK_PIN_OUT(abco), .ALT_BIT_CLK_PIN_OE(abc_e), .WORD_CLK_IN(lclk), .WORD_CLK_OUT(wco),
    .WORD_CLK_OE(wco_e), .ALT_WORD_CLK_PIN_IN(1'b0), .ALT_WORD_CLK_PIN_OUT(awco), .ALT_WORD_CLK_PIN_OE(awc_e),
    .BIT_TICK(btk), .FRAME_TICK(ftk), .TX_DATA(tx_data), .TX_VALID(tx_valid), .SDOUT_OUT(sd_o), .SDOUT_OE(sd_e));
  pdsc_i2c_host u_pdsc_i2c_host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Slave-mode serial clock, 80 ns period, off the core clock rising edges
  initial begin
    lclk = 1'b0;
    forever #40 lclk = ~lclk;
  end
  always @(posedge clk) #1 tx_data = 1'($urandom);
  initial begin
    #600000;
    errors++;
    wrap_up();
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Register model: page 1 hides page 0, reserved low bits read zero
  task automatic wrm(input logic [7:0] o, input logic [7:0] x);
    u_pdsc_i2c_host.wr(o, x);
    if (o == 8'h00) m[0] = x & 8'h01;
    else if (!m[0][0] && o inside {[8'h05:8'h08]}) m[o] = o == 8'h06 ? x & 8'hFC : x;
  endtask : wrm
  task automatic rdc(input logic [7:0] o);
    logic [7:0] r;
    u_pdsc_i2c_host.rd(o, r);
    chk(r, (m[0][0] && o != 8'h00) ? 8'h00 : m[o]);
  endtask : rdc
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  initial begin
    {rst, pwr, alt_b, alt_w, tx_valid} = 5'h11;
    f = 14'h0;
    v = 8'($urandom(28702));
    foreach (m[i]) m[i] = 8'h00;
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    for (int o = 0; o < 10; o++) rdc(8'(o));
    rdc(8'h30);
    chk(pll, 14'h0);
    $display("test 1 done");
    for (int i = 0; i < 3; i++) begin
      d = i == 0 ? 14'd9999 : 14'($urandom_range(9999));
      wrm(8'h05, d[13:6]);
      chk(pll, f);
      wrm(8'h06, {d[5:0], 2'b00});
      f = d;
      chk(pll, f);
      rdc(8'h05);
      rdc(8'h06);
    end
    $display("test 2 done");
    for (int i = 0; i < 4; i++) begin
      run = 1'($urandom);
      v = {i[1], run, run, 2'(i), 2'(3 - i), 1'b0};
      wrm(8'h07, v);
      chk({agc, adc, dac, lr, rr}, v[7:1]);
      rdc(8'h07);
    end
    $display("test 3 done");
    for (int i = 0; i < 4; i++) begin
      alt_b = 1'($urandom);
      alt_w = ~alt_b;
      v = {i[0], i[1], 3'b010, i[0], 2'(i)};
      wrm(8'h08, v);
      chk({e3d, dm_en, dm_os}, {v[2], i != 0, osr[i]});
      chk({bco_e, abc_e, wco_e, awc_e}, {v[7] & ~alt_b, v[7] & alt_b, v[6] & ~alt_w, v[6] & alt_w});
      rdc(8'h08);
    end
    $display("test 4 done");
    for (int i = 0; i < 4; i++) begin
      wrm(8'h08, {2'b00, i[1], 5'h00});
      tx_valid = i[0];
      @(posedge clk) #2 t = tx_data;
      @(posedge clk) #2 chk({sd_e, sd_o}, {~i[1] | i[0], t});
    end
    // Both clocks are slaves now: ticks follow only the selected pin
    for (int i = 0; i < 2; i++) begin
      {alt_b, alt_w} = 2'(i + 1);
      repeat (20) @(posedge clk);
      {bt, wt} = 16'h0;
      repeat (80) begin
        @(posedge clk) #2;
        bt += 8'(btk);
        wt += 8'(ftk);
      end
      chk({bt, wt}, {alt_b ? 8'd0 : 8'd8, alt_w ? 8'd0 : 8'd8});
    end
    $display("test 5 done");
    {alt_b, alt_w} = 2'b00;
    for (int i = 1; i < 4; i++) begin
      wrm(8'h08, {3'b110, i[1], 4'h0});
      pwr = ~i[0];
      repeat (20) @(posedge clk);
      {bt, wt} = 16'h0;
      repeat (80) begin
        {v[1], v[0]} = {bco, wco};
        @(posedge clk) #2;
        bt += 8'(bco !== v[1]);
        wt += 8'(wco !== v[0]);
      end
      chk({bt, wt}, (pwr | i[1]) ? {8'd20, 8'd5} : 16'h0);
      chk({abco, awco}, {bco, wco});
    end
    $display("test 6 done");
    wrm(8'h00, 8'h01);
    rdc(8'h00);
    rdc(8'h05);
    wrm(8'h05, 8'hAA);
    wrm(8'h08, 8'hC4);
    wrm(8'h00, 8'h00);
    rdc(8'h05);
    rdc(8'h08);
    chk({sdo, pll}, {1'b0, f});
    chk(16'(u_pdsc_i2c_host.nacks), 16'h0);
    $display("test 7 done");
    wrap_up();
  end
endmodule : pdsc_config_bank_test
